// ==== include/urx_defines.vh ====
// constants for the receive error, status and queue block
// assumes a 32-bit ahb-lite slave port and one 250 MHz clock
`ifndef URX_DEFINES_VH
`define URX_DEFINES_VH
// register byte offsets
`define URX_ADDR_MODE_ONE   8'h00
`define URX_ADDR_MODE_TWO   8'h04
`define URX_ADDR_STATUS     8'h08
`define URX_ADDR_COMMAND    8'h0C
`define URX_ADDR_DATA       8'h10
`define URX_ADDR_INT_STATUS 8'h14
`define URX_ADDR_CLK_DIV    8'h18
`define URX_ADDR_BID        8'h1C
// mode_reg_one fields
`define URX_M1_PAR_EN   0
`define URX_M1_PAR_ODD  1
`define URX_M1_ERR_BLK  2
`define URX_M1_MULTI    3
// mode_reg_two threshold field
`define URX_M2_THR_HI   3
`define URX_M2_THR_LO   2
// command codes in command_reg[3:0]
`define URX_CMD_RX_EN    4'h1
`define URX_CMD_RX_DIS   4'h2
`define URX_CMD_RX_RST   4'h3
`define URX_CMD_ERR_RST  4'h4
`define URX_CMD_BRK_RST  4'h5
`define URX_CMD_ON_PUSH  4'h6
`define URX_CMD_ON_POP   4'h7
// status bit positions
`define URX_SR_RDY  0
`define URX_SR_FULL 1
`define URX_SR_OVR  4
// queue entry layout
`define URX_Q_BRK 10
`define URX_Q_FE  9
`define URX_Q_PE  8
// fill levels and sizes
`define URX_Q_DEPTH    5'h10
`define URX_LVL_HALF   5'h08
`define URX_LVL_3Q     5'h0C
`define URX_TICK_LAST  4'hF
`define URX_START_MID  4'h7
`define URX_DIV_RESET  8'h01
`endif

// ==== design/urx_queue.v ====
// 16 x 11 receive queue: data byte plus three per-character flags
// assumes push while full comes only together with a pop, which frees the slot
`timescale 1ns/1ps
`default_nettype none
`include "urx_defines.vh"
module urx_queue (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clr,
  input  wire        push,
  input  wire [10:0] wdata,
  input  wire        pop,
  output wire [10:0] head,
  output reg  [4:0]  count
);
  reg [10:0] mem [0:15];  // queue storage
  reg [3:0]  wp;          // write pointer
  reg [3:0]  rp;          // read pointer
  wire       do_push;     // guarded push
  wire       do_pop;      // guarded pop

  // a pop in the same cycle frees the slot, so a full queue still takes the push
  assign do_push = push && ((count != `URX_Q_DEPTH) || do_pop);
  assign do_pop  = pop && (count != 5'h00);
  assign head    = mem[rp];

  // storage write, no reset needed
  always @(posedge hclk) begin
    if (do_push) begin
      mem[wp] <= wdata;
    end
  end

  // pointers and fill count
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp    <= 4'h0;
      rp    <= 4'h0;
      count <= 5'h00;
    end else if (clr) begin
      wp    <= 4'h0;
      rp    <= 4'h0;
      count <= 5'h00;
    end else begin
      if (do_push) begin
        wp <= wp + 4'h1;
      end
      if (do_pop) begin
        rp <= rp + 4'h1;
      end
      if (do_push && !do_pop) begin
        count <= count + 5'h01;
      end else if (do_pop && !do_push) begin
        count <= count - 5'h01;
      end
    end
  end
endmodule // urx_queue
`default_nettype wire

// ==== design/urx_rx_shift.v ====
// serial receiver: start validation, 8 data bits, parity, stop, break
// assumes tick is a one-cycle 16x strobe and rxd is synchronous
`timescale 1ns/1ps
`default_nettype none
`include "urx_defines.vh"
module urx_rx_shift (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       clr,
  input  wire       en,
  input  wire       tick,
  input  wire       rxd,
  input  wire       par_en,
  input  wire       par_odd,
  output reg        start_pulse,
  output reg        done_pulse,
  output reg  [10:0] word,
  output reg        brk_start,
  output reg        brk_end
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_DATA  = 3'd2;
  localparam ST_PAR   = 3'd3;
  localparam ST_STOP  = 3'd4;
  localparam ST_BRK   = 3'd5;
  reg [2:0] state;    // receiver state
  reg [3:0] cnt;      // 16x phase counter
  reg [2:0] nbit;     // data bit index
  reg [7:0] sh;       // shift register
  reg       par_bit;  // received parity bit
  reg       hi_seen;  // one high 1x sample in break
  wire      mid;      // 1x rising edge, bit centre
  wire      calc_par; // computed parity

  assign mid      = tick && (cnt == `URX_TICK_LAST);
  assign calc_par = (^sh) ^ par_odd;

  // receive state machine
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      nbit <= 3'd0;
      sh <= 8'h00;
      par_bit <= 1'b0;
      hi_seen <= 1'b0;
      start_pulse <= 1'b0;
      done_pulse <= 1'b0;
      word <= 11'h000;
      brk_start <= 1'b0;
      brk_end <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      done_pulse <= 1'b0;
      brk_start <= 1'b0;
      brk_end <= 1'b0;
      if (clr || !en) begin
        state <= ST_IDLE;
      end else begin
        if (tick) begin
          cnt <= cnt + 4'h1;
        end
        case (state)
          ST_IDLE: begin
            // falling edge restarts phase counter
            if (!rxd) begin
              state <= ST_START;
              cnt <= 4'h0;
            end
          end
          ST_START: begin
            if (tick && rxd) begin
              state <= ST_IDLE; // reject glitch
            end else if (tick && cnt == `URX_START_MID) begin
              state <= ST_DATA;
              cnt <= 4'h0;
              nbit <= 3'd0;
              start_pulse <= 1'b1;
            end
          end
          ST_DATA: begin
            if (mid) begin
              sh <= {rxd, sh[7:1]};
              nbit <= nbit + 3'd1;
              if (nbit == 3'd7) begin
                state <= par_en ? ST_PAR : ST_STOP;
              end
            end
          end
          ST_PAR: begin
            if (mid) begin
              par_bit <= rxd;
              state <= ST_STOP;
            end
          end
          ST_STOP: begin
            if (mid) begin
              done_pulse <= 1'b1;
              if (sh == 8'h00 && !rxd && !(par_en && par_bit)) begin
                // break: zero byte with break flag
                word <= 11'h400;
                brk_start <= 1'b1;
                hi_seen <= 1'b0;
                state <= ST_BRK;
              end else begin
                word[7:0] <= sh;
                word[`URX_Q_BRK] <= 1'b0;
                word[`URX_Q_FE] <= !rxd;
                word[`URX_Q_PE] <= par_en && (calc_par != par_bit);
                state <= ST_IDLE;
              end
            end
          end
          ST_BRK: begin
            // end needs high at two successive 1x edges
            if (mid) begin
              hi_seen <= rxd;
              if (rxd && hi_seen) begin
                brk_end <= 1'b1;
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // urx_rx_shift
`default_nettype wire

// ==== design/urx_top.v ====
// receive error and queue block with an ahb-lite register slave
// assumes one slave on the bus, single word transfers, rxd synchronous
`timescale 1ns/1ps
`default_nettype none
`include "urx_defines.vh"
module urx_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        rxd,
  output reg         rx_bid_valid,
  output reg  [3:0]  rx_bid_level
);
  // software registers
  reg  [3:0]  mode_reg_one;     // parity, error mode, multidrop
  reg  [3:0]  mode_reg_two;     // threshold in bits 3:2
  reg  [7:0]  clk_div;          // clocks per 16x tick, minus one
  reg         rx_en;            // receiver enable
  reg         on_push;          // block latch set on push
  reg  [2:0]  sticky;           // block mode error latches
  reg         overrun;          // channel_status_reg bit 4
  reg         brk_change;       // interrupt_status_reg bit
  reg         brk_active;       // break in progress
  // holding stage beyond the queue
  reg         hold_valid;       // shift register holds a character
  reg  [10:0] hold_word;        // held character
  // bus pipeline
  reg         pend;             // data phase pending
  reg         pend_write;       // latched direction
  reg  [7:0]  pend_addr;        // latched address
  // tick generator
  reg  [7:0]  div_cnt;          // divider counter
  reg         tick;             // 16x strobe
  // internal nets
  wire        start_pulse;      // validated start bit
  wire        done_pulse;       // character complete
  wire [10:0] rx_word;          // completed character
  wire        brk_start;        // break begins
  wire        brk_end;          // break ended
  wire [10:0] head;             // queue head entry
  wire [4:0]  count;            // queue fill count
  wire        q_full;           // queue full
  wire        q_empty;          // queue empty
  wire        acc;              // address phase accepted
  wire        wr_cmd;           // command register write
  wire [3:0]  cmd;              // command code
  wire        rx_clr;           // receiver reset
  wire        rd_pop;           // data read pops
  wire        q_push;           // queue push
  wire [10:0] q_wdata;          // push word
  wire        err_rst;          // reset-error command
  wire [2:0]  sr_flags;         // status bits 7:5
  wire        bid_ok;           // threshold reached and receiver enabled or multidrop set
  wire [4:0]  count_m1;         // fill count minus one

  // fill threshold check by mode field
  function thresh_met;
    input [1:0] sel;
    input [4:0] cnt;
    begin
      case (sel)
        2'b00: thresh_met = (cnt != 5'h00);
        2'b01: thresh_met = (cnt >= `URX_LVL_HALF);
        2'b10: thresh_met = (cnt >= `URX_LVL_3Q);
        2'b11: thresh_met = (cnt == `URX_Q_DEPTH);
        default: thresh_met = 1'b0;
      endcase
    end
  endfunction

  // bus decode
  assign acc     = hsel && htrans[1] && hready;
  assign wr_cmd  = pend && pend_write && (pend_addr == `URX_ADDR_COMMAND);
  assign cmd     = hwdata[3:0];
  assign rx_clr  = wr_cmd && (cmd == `URX_CMD_RX_RST);
  assign err_rst = wr_cmd && (cmd == `URX_CMD_ERR_RST);
  assign rd_pop  = pend && !pend_write && (pend_addr == `URX_ADDR_DATA) && !q_empty;
  assign q_full  = (count == `URX_Q_DEPTH);
  assign q_empty = (count == 5'h00);

  // held character moves first, otherwise a fresh one goes straight in
  assign q_push  = !rx_clr && ((hold_valid && (!q_full || rd_pop)) ||
                   (!hold_valid && done_pulse && !q_full));
  assign q_wdata = hold_valid ? hold_word : rx_word;

  // status view of the three flags: block mode latches, otherwise those of the head entry
  assign sr_flags = mode_reg_one[`URX_M1_ERR_BLK] ? sticky :
                    (q_empty ? 3'b000 : head[10:8]);
  assign bid_ok = thresh_met(mode_reg_two[`URX_M2_THR_HI:`URX_M2_THR_LO], count)
                  && (rx_en || mode_reg_one[`URX_M1_MULTI]);
  assign count_m1 = count - 5'h01;

  urx_queue u_queue (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (rx_clr),
    .push    (q_push),
    .wdata   (q_wdata),
    .pop     (rd_pop),
    .head    (head),
    .count   (count)
  );

  urx_rx_shift u_rx (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .clr         (rx_clr),
    .en          (rx_en),
    .tick        (tick),
    .rxd         (rxd),
    .par_en      (mode_reg_one[`URX_M1_PAR_EN]),
    .par_odd     (mode_reg_one[`URX_M1_PAR_ODD]),
    .start_pulse (start_pulse),
    .done_pulse  (done_pulse),
    .word        (rx_word),
    .brk_start   (brk_start),
    .brk_end     (brk_end)
  );

  // 16x tick divider
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (div_cnt >= clk_div) begin
      div_cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  // ahb-lite slave: one wait state, then answer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      pend_write <= 1'b0;
      pend_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (pend) begin
      pend <= 1'b0;
      hreadyout <= 1'b1;
    end else if (acc) begin
      pend <= 1'b1;
      pend_write <= hwrite;
      pend_addr <= haddr;
      hreadyout <= 1'b0;
    end
  end

  // read data mux, registered in the wait cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (pend && !pend_write) begin
      case (pend_addr)
        `URX_ADDR_MODE_ONE:   hrdata <= {28'h000_0000, mode_reg_one};
        `URX_ADDR_MODE_TWO:   hrdata <= {28'h000_0000, mode_reg_two};
        `URX_ADDR_STATUS:     hrdata <= {24'h00_0000, sr_flags, overrun, 2'b00, q_full, !q_empty};
        `URX_ADDR_DATA:       hrdata <= {24'h00_0000, q_empty ? 8'h00 : head[7:0]};
        `URX_ADDR_INT_STATUS: hrdata <= {29'h0000_0000, rx_en, brk_active, brk_change};
        `URX_ADDR_CLK_DIV:    hrdata <= {24'h00_0000, clk_div};
        `URX_ADDR_BID:        hrdata <= {27'h000_0000, rx_bid_valid, rx_bid_level};
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // mode, divider and command handling
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg_one <= 4'h0;
      mode_reg_two <= 4'h0;
      clk_div <= `URX_DIV_RESET;
      rx_en <= 1'b0;
      on_push <= 1'b0;
    end else if (pend && pend_write) begin
      case (pend_addr)
        `URX_ADDR_MODE_ONE: mode_reg_one <= hwdata[3:0];
        `URX_ADDR_MODE_TWO: mode_reg_two <= hwdata[3:0];
        `URX_ADDR_CLK_DIV:  clk_div <= hwdata[7:0];
        `URX_ADDR_COMMAND: begin
          case (cmd)
            `URX_CMD_RX_EN:   rx_en <= 1'b1;
            `URX_CMD_RX_DIS:  rx_en <= 1'b0;
            `URX_CMD_RX_RST:  rx_en <= 1'b0;
            `URX_CMD_ON_PUSH: on_push <= 1'b1;
            `URX_CMD_ON_POP:  on_push <= 1'b0;
            default:          on_push <= on_push;
          endcase
        end
        default: rx_en <= rx_en;
      endcase
    end
  end

  // holding stage: newest character replaces the waiting one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_valid <= 1'b0;
      hold_word <= 11'h000;
    end else if (rx_clr) begin
      hold_valid <= 1'b0;
    end else if (done_pulse && (hold_valid || q_full) && !(q_push && !hold_valid)) begin
      hold_valid <= 1'b1;
      hold_word <= rx_word;
    end else if (q_push && hold_valid) begin
      hold_valid <= 1'b0;
    end
  end

  // overrun: start seen with queue and shift register both full
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun <= 1'b0;
    end else if (start_pulse && hold_valid && q_full && !rd_pop) begin
      overrun <= 1'b1;
    end else if (err_rst || rx_clr) begin
      overrun <= 1'b0;
    end
  end

  // block mode latches, set on pop or on push; set beats clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sticky <= 3'b000;
    end else begin
      sticky <= ((err_rst || rx_clr) ? 3'b000 : sticky) |
                ((on_push && q_push) ? q_wdata[10:8] : 3'b000) |
                ((!on_push && rd_pop) ? head[10:8] : 3'b000);
    end
  end

  // break change and active tracking
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_change <= 1'b0;
      brk_active <= 1'b0;
    end else begin
      if (brk_start || brk_end) begin
        brk_change <= 1'b1;
      end else if (rx_clr || (wr_cmd && cmd == `URX_CMD_BRK_RST)) begin
        brk_change <= 1'b0;
      end
      if (brk_start) begin
        brk_active <= 1'b1;
      end else if (brk_end || rx_clr) begin
        brk_active <= 1'b0;
      end
    end
  end

  // interrupt bid: fill count minus one, none when empty
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_bid_valid <= 1'b0;
      rx_bid_level <= 4'h0;
    end else begin
      rx_bid_valid <= bid_ok;
      rx_bid_level <= q_empty ? 4'h0 : count_m1[3:0];
    end
  end
endmodule // urx_top
`default_nettype wire

// ==== sim/urx_sva.sv ====
// assertion checker for the receive queue block, bound to urx_top
// assumes the lone ahb-lite slave drives the bus hready itself
`timescale 1ns/1ps
`default_nettype none
`include "urx_defines.vh"
module urx_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rxd,
  input wire logic        rx_bid_valid,
  input wire logic [3:0]  rx_bid_level
);
  logic       wp, rp;          // write or read data phase pending
  logic       en, en_d, mu, mu_d; // mirrored enable and multidrop
  logic [7:0] wa;              // address of the pending data phase
  logic [1:0] thr, thr_d;      // mirrored fill threshold code
  logic [1:0] rs;              // trail of an rx reset command
  wire        cmt = wp && hreadyout; // a write lands at this edge
  // mirror of control writes seen on the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wp, rp, en, en_d, mu, mu_d, wa, thr, thr_d, rs} <= '0;
    end else begin
      if (hreadyout) begin
        wp <= hsel && htrans[1] && hwrite;
        rp <= hsel && htrans[1] && !hwrite;
        wa <= haddr;
      end
      if (cmt && wa == `URX_ADDR_MODE_ONE) mu <= hwdata[`URX_M1_MULTI];
      if (cmt && wa == `URX_ADDR_MODE_TWO) thr <= hwdata[3:2];
      if (cmt && wa == `URX_ADDR_COMMAND && hwdata[3:0] == `URX_CMD_RX_EN) en <= 1'b1;
      if (cmt && wa == `URX_ADDR_COMMAND && hwdata[3:1] == 3'b001) en <= 1'b0;
      rs <= {rs[0], cmt && wa == `URX_ADDR_COMMAND && hwdata[3:0] == `URX_CMD_RX_RST};
      {en_d, mu_d, thr_d} <= {en, mu, thr};
    end
  end
  // lowest bid level at which each threshold code lets a bid out
  function automatic logic [3:0] lvl(input logic [1:0] t);
    return (t == 2'd0) ? 4'h0 : (t == 2'd1) ? 4'h7 : (t == 2'd2) ? 4'hB : 4'hF;
  endfunction
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_gap;
    !hreadyout ##1 hreadyout;
  endsequence
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  wait_one_a: assert property (hsel && htrans[1] && hreadyout |=> s_gap) else $error("wait state not one cycle");
  rdata_hold_a: assert property ($changed(hrdata) |-> rp) else $error("read data moved outside a read");
  rd_zero_a: assert property (rp && hreadyout && wa >= 8'h20 |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  bid_thresh_a: assert property (rx_bid_valid && thr == thr_d |-> rx_bid_level >= lvl(thr_d))
    else $error("bid below threshold");
  bid_fill_a: assert property (en && en_d && thr == thr_d && thr != 2'd0 && rx_bid_level >= lvl(thr)
    |-> rx_bid_valid) else $error("bid missing at threshold");
  bid_off_a: assert property (!en && !en_d && !mu && !mu_d |-> !rx_bid_valid)
    else $error("disabled receiver bids");
  bid_step_a: assert property (!rs[0] && !rs[1] |->
    4'(rx_bid_level - $past(rx_bid_level)) inside {4'h0, 4'h1, 4'hF}) else $error("bid level jumped");
endmodule // urx_sva
bind urx_top urx_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .rxd(rxd), .rx_bid_valid(rx_bid_valid), .rx_bid_level(rx_bid_level));
`default_nettype wire

// ==== sim/urx_ser_model.sv ====
// remote serial transmitter driving the receive line
// assumes the receiver tick runs every clock, so one bit is 16 clocks
`timescale 1ns/1ps
`default_nettype none
module urx_ser_model #(parameter int BIT_CLKS = 16) (
  input  wire logic hclk,
  output var  logic rxd
);
  initial rxd = 1'b1; // line idles at mark
  // hold one level for a bit time, changed just after an edge
  task automatic bit_out(input logic v);
    rxd <= v;
    repeat (BIT_CLKS) @(posedge hclk);
  endtask
  // start, data lsb first, even parity (optionally spoiled), stop, one idle bit
  task automatic send(input logic [7:0] d, input logic bad, input logic stop);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    bit_out(^d ^ bad);
    bit_out(stop);
    bit_out(1'b1);
  endtask
endmodule // urx_ser_model
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the receive error and queue block
// assumes tick every clock (divider 0), even parity on, one bus master
`timescale 1ns/1ps
`default_nettype none
`include "urx_defines.vh"
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;        // whole words only
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, r;             // bus read data, last word taken
  logic        hreadyout, hresp, rxd, rx_bid_valid;
  logic [3:0]  rx_bid_level;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          lv[4] = '{1, 8, 12, 16}; // fill counts per threshold code
  always #2 hclk = ~hclk;             // 250 MHz
  urx_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rxd(rxd), .rx_bid_valid(rx_bid_valid), .rx_bid_level(rx_bid_level));
  urx_ser_model u_ser (.hclk(hclk), .rxd(rxd));
  // one single transfer: address phase, then data phase, each until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // read and compare the masked bits
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    samples_checked++;
    if ((r & m) !== e) begin
      fail_count++;
      $display("unexpected at %0t: addr %h gave %h not %h", $time, a, r & m, e);
    end
  endtask
  // verdict and end of run
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`URX_ADDR_CLK_DIV, 32'h0000_00FF, {24'h00_0000, `URX_DIV_RESET});
    rd(`URX_ADDR_INT_STATUS, 32'h0000_0007, 32'h0000_0000);
    wr(8'h24, 32'hFFFF_FFFF);
    rd(8'h24, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`URX_ADDR_CLK_DIV, 32'h0000_0000);
    wr(`URX_ADDR_MODE_ONE, 32'h0000_0001);
    wr(`URX_ADDR_COMMAND, {28'h000_0000, `URX_CMD_RX_EN});
    // good, bad parity, bad stop: flags follow the head only
    u_ser.send(8'h55, 1'b0, 1'b1);
    u_ser.send(8'hA3, 1'b1, 1'b1);
    u_ser.send(8'h3C, 1'b0, 1'b0);
    rd(`URX_ADDR_STATUS, 32'h0000_00E1, 32'h0000_0001);
    rd(`URX_ADDR_BID, 32'h0000_001F, 32'h0000_0012);
    rd(`URX_ADDR_DATA, 32'h0000_00FF, 32'h0000_0055);
    rd(`URX_ADDR_STATUS, 32'h0000_00E0, 32'h0000_0020);
    rd(`URX_ADDR_DATA, 32'h0000_00FF, 32'h0000_00A3);
    rd(`URX_ADDR_STATUS, 32'h0000_00E0, 32'h0000_0040);
    rd(`URX_ADDR_DATA, 32'h0000_00FF, 32'h0000_003C);
    rd(`URX_ADDR_STATUS, 32'h0000_00E1, 32'h0000_0000);
    // break: line low for twelve bit times, then released
    repeat (12) u_ser.bit_out(1'b0);
    rd(`URX_ADDR_INT_STATUS, 32'h0000_0003, 32'h0000_0003);
    rd(`URX_ADDR_STATUS, 32'h0000_0080, 32'h0000_0080);
    wr(`URX_ADDR_COMMAND, {28'h000_0000, `URX_CMD_BRK_RST});
    u_ser.bit_out(1'b1);
    repeat (32) @(posedge hclk);
    rd(`URX_ADDR_INT_STATUS, 32'h0000_0003, 32'h0000_0001);
    rd(`URX_ADDR_DATA, 32'h0000_00FF, 32'h0000_0000);
    // block reporting, latched on pop, then on push
    wr(`URX_ADDR_MODE_ONE, 32'h0000_0005);
    wr(`URX_ADDR_COMMAND, {28'h000_0000, `URX_CMD_ERR_RST});
    u_ser.send(8'h11, 1'b1, 1'b1);
    u_ser.send(8'h22, 1'b0, 1'b1);
    rd(`URX_ADDR_DATA, 32'h0000_00FF, 32'h0000_0011);
    rd(`URX_ADDR_STATUS, 32'h0000_00E0, 32'h0000_0020);
    rd(`URX_ADDR_DATA, 32'h0000_00FF, 32'h0000_0022);
    rd(`URX_ADDR_STATUS, 32'h0000_00E0, 32'h0000_0020);
    wr(`URX_ADDR_COMMAND, {28'h000_0000, `URX_CMD_ERR_RST});
    rd(`URX_ADDR_STATUS, 32'h0000_00E0, 32'h0000_0000);
    wr(`URX_ADDR_COMMAND, {28'h000_0000, `URX_CMD_ON_PUSH});
    u_ser.send(8'h33, 1'b1, 1'b1);
    rd(`URX_ADDR_STATUS, 32'h0000_00E0, 32'h0000_0020);
    rd(`URX_ADDR_DATA, 32'h0000_00FF, 32'h0000_0033);
    wr(`URX_ADDR_COMMAND, {28'h000_0000, `URX_CMD_ON_POP});
    wr(`URX_ADDR_COMMAND, {28'h000_0000, `URX_CMD_ERR_RST});
    wr(`URX_ADDR_MODE_ONE, 32'h0000_0001);
    // fill to 16, trying every threshold code at each level
    for (int k = 1; k <= 16; k++) begin
      u_ser.send(8'(8'h40 + k), 1'b0, 1'b1);
      for (int t = 0; t < 4; t++) begin
        wr(`URX_ADDR_MODE_TWO, 32'(t) << 2);
        rd(`URX_ADDR_BID, 32'h0000_001F, {27'h0, k >= lv[t], 4'(k - 1)});
      end
    end
    rd(`URX_ADDR_STATUS, 32'h0000_0013, 32'h0000_0003);
    u_ser.send(8'hE1, 1'b0, 1'b1);
    rd(`URX_ADDR_STATUS, 32'h0000_0013, 32'h0000_0003);
    fork
      u_ser.send(8'hE2, 1'b0, 1'b1);
      begin
        repeat (14) @(posedge hclk);
        rd(`URX_ADDR_STATUS, 32'h0000_0010, 32'h0000_0010);
      end
    join
    rd(`URX_ADDR_DATA, 32'h0000_00FF, 32'h0000_0041);
    rd(`URX_ADDR_BID, 32'h0000_001F, 32'h0000_001F);
    for (int i = 2; i <= 16; i++) rd(`URX_ADDR_DATA, 32'h0000_00FF, 32'(8'h40 + i));
    rd(`URX_ADDR_DATA, 32'h0000_00FF, 32'h0000_00E2);
    rd(`URX_ADDR_STATUS, 32'h0000_0011, 32'h0000_0010);
    wr(`URX_ADDR_COMMAND, {28'h000_0000, `URX_CMD_ERR_RST});
    rd(`URX_ADDR_STATUS, 32'h0000_0010, 32'h0000_0000);
    // disable, multidrop and receiver reset
    wr(`URX_ADDR_MODE_TWO, 32'h0000_0000);
    u_ser.send(8'h66, 1'b0, 1'b1);
    wr(`URX_ADDR_COMMAND, {28'h000_0000, `URX_CMD_RX_DIS});
    rd(`URX_ADDR_BID, 32'h0000_001F, 32'h0000_0000);
    u_ser.send(8'h77, 1'b0, 1'b1);
    rd(`URX_ADDR_BID, 32'h0000_001F, 32'h0000_0000);
    wr(`URX_ADDR_MODE_ONE, 32'h0000_0009);
    rd(`URX_ADDR_BID, 32'h0000_001F, 32'h0000_0010);
    wr(`URX_ADDR_COMMAND, {28'h000_0000, `URX_CMD_RX_RST});
    rd(`URX_ADDR_BID, 32'h0000_001F, 32'h0000_0000);
    rd(`URX_ADDR_INT_STATUS, 32'h0000_0004, 32'h0000_0000);
    stop_test();
  end
  // watchdog against a hung handshake
  initial begin
    #200000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // tb
`default_nettype wire
